// file: iip_checker.sv
`default_nettype none
module iip_checker
	import iip_pkg::*;
(
	input wire logic        sys_clk_i,
	input wire logic        rst_i,
	input wire logic [7:0]  bank_a_pin_i,
	input wire logic [7:0]  bank_b_pin_i,
	input wire logic        io_sel_i,
	input wire iip_io_req_t io_req_i,
	input wire logic [7:0]  io_rdata_o,
	input wire logic        io_rvalid_o,
	input wire logic        irq_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	wire logic rd = io_sel_i && io_req_i.rd;
	wire logic [2:0] ad = io_req_i.addr;
	AST_RD_ANS: assert property (rd |=> io_rvalid_o) else $error("read unanswered");
	AST_NO_SEL: assert property (!rd |=> !io_rvalid_o) else $error("stray answer");
	AST_IDLE: assert property (!io_rvalid_o |-> io_rdata_o == 8'h00) else $error("idle data");
	AST_UNMAP: assert property (rd && ad inside {[2:4], 6, 7} |=> io_rdata_o == 8'h00)
		else $error("unmapped data");
	AST_CTRL0: assert property (rd && ad == OFS_IRQ_CTRL |=> io_rdata_o[5:2] == 4'h0)
		else $error("control zeros");
	AST_PEND: assert property (io_rvalid_o && $past(rd && ad == OFS_IRQ_CTRL) &&
		!$past(io_sel_i && io_req_i.wr, 2) |->
		$past(irq_o) == (io_rdata_o[7] && io_rdata_o[6])) else $error("irq vs status");
	AST_A_DATA: assert property ($stable(bank_a_pin_i)[*6] ##0 rd && ad == OFS_BANK_A
		|=> io_rdata_o == $past(bank_a_pin_i)) else $error("bank a data");
	AST_B_DATA: assert property ($stable(bank_b_pin_i)[*6] ##0 rd && ad == OFS_BANK_B
		|=> io_rdata_o == $past(bank_b_pin_i)) else $error("bank b data");
	cover property (rd && ad == OFS_IRQ_CTRL ##1 irq_o);
	cover property (rd && ad == 3'h2);
	cover property (!io_sel_i && io_req_i.rd);
endmodule
bind iip_port_pair iip_checker chk_i (.sys_clk_i, .rst_i, .bank_a_pin_i, .bank_b_pin_i,
	.io_sel_i, .io_req_i, .io_rdata_o, .io_rvalid_o, .irq_o);
`default_nettype wire

// file: iip_pin_sync.sv
`default_nettype none
// three-stage sampler: a change is accepted once stages two and three agree
module iip_pin_sync
	import iip_pkg::*;
#(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             sys_clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] level_o
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);
	wire  [WIDTH-1:0] next_level = (agree & stage3) | (~agree & level_o);

	// idle inputs read as 1, so reset to that level to avoid a false edge
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			stage1  <= {WIDTH{RST_SYNC}};
			stage2  <= {WIDTH{RST_SYNC}};
			stage3  <= {WIDTH{RST_SYNC}};
			level_o <= {WIDTH{RST_SYNC}};
		end else begin
			stage1  <= pin_i;
			stage2  <= stage1;
			stage3  <= stage2;
			level_o <= next_level;
		end
	end
endmodule
`default_nettype wire

// file: iip_pkg.sv
`default_nettype none
package iip_pkg;
	localparam int unsigned PORT_WIDTH = 8;
	localparam int unsigned ADDR_WIDTH = 3;
	// byte offsets from the card's assigned I/O base
	localparam logic [2:0] OFS_BANK_A = 3'h0;
	localparam logic [2:0] OFS_BANK_B = 3'h1;
	localparam logic [2:0] OFS_IRQ_CTRL = 3'h5;
	// control byte field positions
	localparam int unsigned POS_TRIG_LO = 0;
	localparam int unsigned POS_PENDING = 6;
	localparam int unsigned POS_ALLOW = 7;
	// values after reset
	localparam logic [1:0] RST_TRIG_SEL = 2'h0;
	localparam logic RST_ALLOW = 1'h0;
	localparam logic RST_FLAG = 1'h0;
	localparam logic RST_SYNC = 1'h1;
	localparam logic [7:0] RST_RDATA = 8'h00;

	typedef enum logic [1:0] {
		IIP_TRIG_LOW_LEVEL,
		IIP_TRIG_HIGH_LEVEL,
		IIP_TRIG_FALL_EDGE,
		IIP_TRIG_RISE_EDGE
	} iip_trig_t;

	typedef struct packed {
		logic                  rd;
		logic                  wr;
		logic [ADDR_WIDTH-1:0] addr;
		logic [7:0]            wdata;
	} iip_io_req_t;
endpackage
`default_nettype wire

// file: iip_port_pair.sv
`default_nettype none
// Overview of operation
// - two independent eight-bit input ports, A and B, one bit per sensor.
// - a read at offset 0 returns the port A bits.
// - a read at offset 1 returns the port B bits.
// - an energised sensor reads as 0.
// - a weak or absent sensor reads as 1.
// - port A bit 0 is the only interrupt source.
// - no output ports; writes to port A or B change nothing.
// - two-bit trigger select at offset 5: low, high, falling, rising.
// - interrupt allow bit at offset 5, cleared by reset.
// - pending flag at offset 5 reads 1, clears on read, ignores writes.
// - level modes do not set pending again until port A bit 0 changes state.
module iip_port_pair
	import iip_pkg::*;
#(
	parameter int unsigned PORT_BITS = PORT_WIDTH
) (
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_i,
	input  wire logic [PORT_BITS-1:0] bank_a_pin_i,
	input  wire logic [PORT_BITS-1:0] bank_b_pin_i,
	input  wire logic                 io_sel_i,
	input  wire iip_io_req_t          io_req_i,
	output logic      [7:0]           io_rdata_o,
	output logic                      io_rvalid_o,
	output logic                      irq_o
);
	logic [PORT_BITS-1:0] bank_a;
	logic [PORT_BITS-1:0] bank_b;
	logic [1:0]           interrupt_trigger_select;
	logic                 interrupt_allow_bit;
	logic                 interrupt_pending_flag;
	logic                 level_latched;
	logic                 src_prev;
	logic                 cond_hit;
	logic [7:0]           ctrl_byte;
	iip_trig_t            trig;

	// pins carry the isolator output: on drives low, off floats high
	iip_pin_sync #(
		.WIDTH(PORT_BITS)
	) u_sync_a (
		.sys_clk_i(sys_clk_i),
		.rst_i    (rst_i),
		.pin_i    (bank_a_pin_i),
		.level_o  (bank_a)
	);

	iip_pin_sync #(
		.WIDTH(PORT_BITS)
	) u_sync_b (
		.sys_clk_i(sys_clk_i),
		.rst_i    (rst_i),
		.pin_i    (bank_b_pin_i),
		.level_o  (bank_b)
	);

	// offset compare shared by every register decode
	function automatic logic hit(
		input iip_io_req_t r,
		input logic [2:0]  ofs
	);
		hit = (r.addr == ofs);
	endfunction

	// a bank onto the byte lane, cut or zero-padded on purpose
	function automatic logic [7:0] to_byte(
		input logic [PORT_BITS-1:0] bits
	);
		to_byte = 8'(bits);
	endfunction

	// io_sel_i is the host's decode of the assigned base window
	wire acc_rd = io_sel_i & io_req_i.rd;
	wire acc_wr = io_sel_i & io_req_i.wr;

	// read strobes, one per mapped offset
	wire rd_a    = acc_rd & hit(io_req_i, OFS_BANK_A);
	wire rd_b    = acc_rd & hit(io_req_i, OFS_BANK_B);
	wire rd_ctrl = acc_rd & hit(io_req_i, OFS_IRQ_CTRL);

	// writes to the port offsets fall through: nothing is stored there
	wire wr_ctrl = acc_wr & hit(io_req_i, OFS_IRQ_CTRL);

	// the pending bit of the write data is dropped: only hardware sets it
	wire [1:0] wr_trig  = io_req_i.wdata[POS_TRIG_LO +: 2];
	wire       wr_allow = io_req_i.wdata[POS_ALLOW];

	wire [7:0] a_byte = to_byte(bank_a);
	wire [7:0] b_byte = to_byte(bank_b);

	// unused control bits read as zero
	always_comb begin
		ctrl_byte                   = RST_RDATA;
		ctrl_byte[POS_TRIG_LO +: 2] = interrupt_trigger_select;
		ctrl_byte[POS_PENDING]      = interrupt_pending_flag;
		ctrl_byte[POS_ALLOW]        = interrupt_allow_bit;
	end

	// other offsets in the window read as zero
	wire [7:0] next_rdata = rd_a ? a_byte :
		rd_b ? b_byte :
		rd_ctrl ? ctrl_byte :
		RST_RDATA;

	// the source is the filtered pin, so its edges carry no glitches
	wire src      = bank_a[0];
	wire src_rise = src & ~src_prev;
	wire src_fall = ~src & src_prev;
	wire src_chg  = src ^ src_prev;

	// every two-bit code is a legal mode, so no default is needed
	assign trig = iip_trig_t'(interrupt_trigger_select);

	always_comb begin
		unique case (trig)
			IIP_TRIG_LOW_LEVEL: begin
				cond_hit = ~src;
			end
			IIP_TRIG_HIGH_LEVEL: begin
				cond_hit = src;
			end
			IIP_TRIG_FALL_EDGE: begin
				cond_hit = src_fall;
			end
			IIP_TRIG_RISE_EDGE: begin
				cond_hit = src_rise;
			end
		endcase
	end

	// the host should clear allow before changing mode, or a match may fire
	wire level_mode = (trig == IIP_TRIG_LOW_LEVEL) ||
		(trig == IIP_TRIG_HIGH_LEVEL);

	// a level event may not re-arm until the source has toggled, else a
	// read would clear pending only for the still-true level to set it again
	wire cond_new = cond_hit & ~(level_mode & level_latched);
	wire set_pend = interrupt_allow_bit & cond_new;

	// set wins over the clear of a simultaneous read
	wire next_pending = set_pend | (interrupt_pending_flag & ~rd_ctrl);
	wire next_latched = level_mode & ((level_latched & ~src_chg) | set_pend);

	// clearing allow masks the request but keeps pending for a later poll
	wire next_irq = next_pending & interrupt_allow_bit;

	// trigger select changes only on a write of the control byte
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			interrupt_trigger_select <= RST_TRIG_SEL;
		end else if (wr_ctrl) begin
			interrupt_trigger_select <= wr_trig;
		end
	end

	// interrupts stay off after reset until the host allows them
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			interrupt_allow_bit <= RST_ALLOW;
		end else if (wr_ctrl) begin
			interrupt_allow_bit <= wr_allow;
		end
	end

	// set by the selected condition, cleared by a read of the control byte
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			interrupt_pending_flag <= RST_FLAG;
		end else begin
			interrupt_pending_flag <= next_pending;
		end
	end

	// remembers a level event already reported
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			level_latched <= RST_FLAG;
		end else begin
			level_latched <= next_latched;
		end
	end

	// one cycle of history for the edge detector, idle level after reset
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			src_prev <= RST_SYNC;
		end else begin
			src_prev <= src;
		end
	end

	// read data stands for one cycle and is zero otherwise
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			io_rdata_o <= RST_RDATA;
		end else begin
			io_rdata_o <= next_rdata;
		end
	end

	// every selected read is answered, mapped or not
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			io_rvalid_o <= RST_FLAG;
		end else begin
			io_rvalid_o <= acc_rd;
		end
	end

	// level request to the host, registered so the pin carries no glitch
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_o <= RST_FLAG;
		end else begin
			irq_o <= next_irq;
		end
	end
endmodule
`default_nettype wire

// file: iip_sensor_model.sv
`default_nettype none
module iip_sensor_model (
	input  wire logic [15:0] energised_i,
	output logic      [7:0]  bank_a_pin_o,
	output logic      [7:0]  bank_b_pin_o
);
	// an energised sensor turns its isolator on, pulling the line low
	assign {bank_b_pin_o, bank_a_pin_o} = ~energised_i;
endmodule
`default_nettype wire

// file: isolated_input_port_pair_bench.sv
`default_nettype none
module isolated_input_port_pair_bench
	import iip_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk_i = 1'h0, rst_i = 1'h1, io_sel_i = 1'h1, io_rvalid_o, irq_o, qv;
	logic [15:0] energised = 16'h0000;
	logic [7:0]  pa, pb, io_rdata_o, q;
	iip_io_req_t io_req_i = '0;
	int          n_errors = 0, check_count = 0;
	always #20 sys_clk_i = ~sys_clk_i;
	iip_sensor_model sensors (.energised_i(energised), .bank_a_pin_o(pa), .bank_b_pin_o(pb));
	iip_port_pair dut (.sys_clk_i, .rst_i, .bank_a_pin_i(pa), .bank_b_pin_i(pb),
		.io_sel_i, .io_req_i, .io_rdata_o, .io_rvalid_o, .irq_o);
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one cycle request, data taken at the falling edge after the answer edge
	task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(negedge sys_clk_i) io_req_i = '{rd: !w, wr: w, addr: a, wdata: d};
		@(negedge sys_clk_i) io_req_i = '0;
		q = io_rdata_o;
		qv = io_rvalid_o;
	endtask
	task automatic wirq(input logic e);
		for (int i = 0; i < 12 && irq_o !== e; i++) @(negedge sys_clk_i);
		chk("irq", {7'h00, e}, {7'h00, irq_o});
		if (irq_o !== e) results();
	endtask
	task automatic t_ports;
		energised = 16'h3C81;
		repeat (8) @(negedge sys_clk_i);
		acc(1'h0, OFS_BANK_A, 8'h00);
		chk("bank a", 8'h7E, q);
		chk("bank a valid", 8'h01, {7'h00, qv});
		acc(1'h0, OFS_BANK_B, 8'h00);
		chk("bank b", 8'hC3, q);
		acc(1'h1, OFS_BANK_A, 8'hFF);
		chk("write valid", 8'h00, {7'h00, qv});
		acc(1'h0, OFS_BANK_A, 8'h00);
		chk("bank a after write", 8'h7E, q);
	endtask
	task automatic t_decode;
		io_sel_i = 1'h0;
		acc(1'h0, OFS_BANK_A, 8'h00);
		chk("unselected", 8'h00, q);
		chk("unselected valid", 8'h00, {7'h00, qv});
		io_sel_i = 1'h1;
		acc(1'h0, 3'h2, 8'h00);
		chk("unmapped", 8'h00, q);
	endtask
	task automatic t_irq;
		for (int m = 0; m < 4; m++) begin
			acc(1'h1, OFS_IRQ_CTRL, 8'(m));
			acc(1'h0, OFS_IRQ_CTRL, 8'h00);
			chk("trigger select", 8'(m), q);
		end
		acc(1'h1, OFS_IRQ_CTRL, 8'hC3);
		acc(1'h0, OFS_IRQ_CTRL, 8'h00);
		chk("pending not writable", 8'h83, q);
		energised = 16'h3C80;
		wirq(1'h1);
		acc(1'h0, OFS_IRQ_CTRL, 8'h00);
		chk("pending read", 8'hC3, q);
		wirq(1'h0);
		acc(1'h1, OFS_IRQ_CTRL, 8'h80);
		energised = 16'h3C81;
		wirq(1'h1);
		acc(1'h0, OFS_IRQ_CTRL, 8'h00);
		chk("level pending", 8'hC0, q);
		// the level still matches, yet it must not re-arm without a toggle
		repeat (8) @(negedge sys_clk_i);
		wirq(1'h0);
		acc(1'h0, OFS_IRQ_CTRL, 8'h00);
		chk("level no rearm", 8'h80, q);
		// a toggle of the source re-arms the level event
		energised = 16'h3C80;
		repeat (8) @(negedge sys_clk_i);
		energised = 16'h3C81;
		wirq(1'h1);
		acc(1'h0, OFS_IRQ_CTRL, 8'h00);
		chk("level rearm", 8'hC0, q);
		acc(1'h1, OFS_IRQ_CTRL, 8'h82);
		energised = 16'h3C80;
		repeat (8) @(negedge sys_clk_i);
		acc(1'h0, OFS_IRQ_CTRL, 8'h00);
		chk("no fall on rise", 8'h82, q);
		energised = 16'h3C81;
		wirq(1'h1);
		acc(1'h0, OFS_IRQ_CTRL, 8'h00);
		chk("fall pending", 8'hC2, q);
		acc(1'h1, OFS_IRQ_CTRL, 8'h81);
		energised = 16'h3C80;
		wirq(1'h1);
		acc(1'h0, OFS_IRQ_CTRL, 8'h00);
		chk("high level pending", 8'hC1, q);
	endtask
	task automatic t_reset;
		acc(1'h1, OFS_IRQ_CTRL, 8'h83);
		@(negedge sys_clk_i) rst_i = 1'h1;
		repeat (2) @(negedge sys_clk_i);
		rst_i = 1'h0;
		acc(1'h0, OFS_IRQ_CTRL, 8'h00);
		chk("control after reset", 8'h00, q);
		chk("irq after reset", 8'h00, {7'h00, irq_o});
	endtask
	initial begin
		repeat (10) @(negedge sys_clk_i);
		rst_i = 1'h0;
		t_ports();
		t_decode();
		t_irq();
		t_reset();
		results();
	end
endmodule
`default_nettype wire
